// ==== src/wcd_core.sv ====
`timescale 1ns/1ps
// Function
// RULE1 - Fixed 18-bit word, first register is destination
// RULE2 - Primary opcode from bits 17 to 13
// RULE3 - Codes 01000-01111 are register-immediate operations
// RULE4 - Codes 10000-10111 are memory and shifts
// RULE5 - Immediate compares set flag; conditional add/sub
// RULE6 - Group one sub-decode of bits 4 to 0
// RULE7 - Group two sub-decode of bits 4 to 0
// RULE8 - Flag or/and and unused codes unsupported
// RULE9 - Sixteen registers mapped into 1k x 18 store
// RULE10 - Window shift advances base by eight entries
// RULE11 - Special registers hold until next access
// RULE12 - Status bits 6:0 hold window level
// RULE13 - Status bit 7 enables address bit 17
// RULE14 - Status bit 8 gates hardware interrupts
// RULE15 - Special register 1 drives indicator outputs
// RULE16 - Special register 2 holds product high half
// RULE17 - Special register 3 bit 0 is flag
// RULE18 - Special register 4 is handler start address
// RULE19 - Special register 5 trap base and number; the number bits read back as zero
// RULE20 - Debug index/data pair reads zero without debug
// RULE21 - Signed add sets flag on overflow
// RULE22 - Addi sign-extends; addu keeps flag; and conjunction
// RULE23 - Bit numbers 0,1,2 select flag, upper, allow
// RULE24 - Call increments level, links R11, then jumps
// RULE25 - Window return jumps and decrements level
// RULE26 - Every transfer has one delay slot
// RULE27 - Unused opcodes act as no-operation
module wcd_core
  import wcd_pkg::*;
#(
  parameter logic [17:0] HANDLER_RESET = 18'h00000,
  parameter bit          DEBUG_EN      = 1'b0
) (
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire logic          instr_valid,
  input  wire logic [17:0]   instr,
  input  wire logic [17:0]   instr_pc,
  input  wire logic          ld_valid,
  input  wire logic [17:0]   ld_data,
  input  wire logic          irq_req,
  output wcd_redirect_t      redirect,
  output wcd_mem_req_t       mem_req,
  output logic [6:0]         indicators,
  output logic               irq_take,
  output logic               interrupt_allow,
  output logic [6:0]         window_level,
  output logic               condition_flag
);

  // ==========================================================================
  // Helper functions
  // ==========================================================================

  // Globals live at the bottom entries; windowed registers sit at eight per level,
  // so registers 12 to 15 of one level alias registers 4 to 7 of the next.
  function automatic logic [9:0] phys_idx(input logic [6:0] lvl, input logic [3:0] r);
    if (r <= REG_GLOBAL_TOP) begin
      phys_idx = {6'h00, r};
    end else begin
      phys_idx = {lvl, 3'h0} + {6'h00, r}; // RULE9 RULE10
    end
  endfunction : phys_idx

  function automatic logic [17:0] sext9(input logic [8:0] v);
    sext9 = {{9{v[8]}}, v};
  endfunction : sext9

  // Compare selector shared by all three compare families.
  function automatic logic cmp_sel(input logic [2:0] sel, input logic eq, input logic lt);
    case (sel)
      3'h0:    cmp_sel = eq;
      3'h1:    cmp_sel = !eq;
      3'h2:    cmp_sel = lt;
      3'h3:    cmp_sel = !lt && !eq;
      3'h4:    cmp_sel = lt || eq;
      default: cmp_sel = !lt;
    endcase
  endfunction : cmp_sel

  // Signed overflow of a sum or difference already formed at 18 bits.
  function automatic logic ovf(input logic [17:0] a, input logic [17:0] b,
                               input logic [17:0] s, input logic sub);
    logic [17:0] bb;
    bb  = sub ? ~b : b;
    ovf = (a[17] == bb[17]) && (s[17] != a[17]);
  endfunction : ovf

  // ==========================================================================
  // State
  // ==========================================================================
  wcd_state_t st_r;
  wcd_state_t st_nxt;

  logic [4:0]  op;
  logic [4:0]  fn;
  logic [3:0]  rd;
  logic [3:0]  rs;
  logic [9:0]  rd_idx;
  logic [9:0]  rs_idx;
  logic [17:0] a;
  logic [17:0] b;
  logic [17:0] imm_s;
  logic [17:0] imm_z;
  logic [35:0] prod;
  logic [17:0] sum;
  logic [17:0] spr_rd;
  logic [17:0] link_pc;
  logic [17:0] maddr;

  // Field extraction: register forms name Rd in 12:9 and Rs in 8:5.
  assign op      = instr[17:13]; // RULE1 RULE2
  assign rd      = instr[12:9];
  assign rs      = instr[8:5];
  assign fn      = instr[4:0];
  assign rd_idx  = phys_idx(st_r.level, rd);
  assign rs_idx  = phys_idx(st_r.level, rs);
  assign a       = st_r.rf[rd_idx];
  assign b       = st_r.rf[rs_idx];
  assign imm_s   = sext9(instr[8:0]);
  assign imm_z   = {9'h000, instr[8:0]};
  assign link_pc = instr_pc + 18'h00002;
  assign maddr   = b + {13'h0000, fn};

  // Special register read mux; trap number bits always read back as zero.
  always_comb begin
    if (rs == SPR_STATUS) begin
      spr_rd = {9'h000, st_r.allow, st_r.upper, st_r.level};
    end else if (rs == SPR_IND) begin
      spr_rd = {11'h000, st_r.ind};
    end else if (rs == SPR_MULHI) begin
      spr_rd = st_r.mulhi;
    end else if (rs == SPR_FLAG) begin
      spr_rd = {17'h00000, st_r.flag};
    end else if (rs == SPR_HSTART) begin
      spr_rd = st_r.hstart;
    end else if (rs == SPR_TRAP) begin
      spr_rd = {st_r.tbase, 8'h00}; // RULE19
    end else if (rs == SPR_DBGIDX) begin
      spr_rd = DEBUG_EN ? st_r.dbg_idx : RST_ZERO; // RULE20
    end else if (rs == SPR_DBGDAT) begin
      spr_rd = DEBUG_EN ? st_r.dbg_dat : RST_ZERO; // RULE20
    end else begin
      spr_rd = RST_ZERO;
    end
  end

  // ==========================================================================
  // Next-state logic
  // ==========================================================================

  // One process decodes and executes; the product and sums are formed once here
  // and reused, trading a little depth for a single adder per operation kind.
  always_comb begin
    st_nxt       = st_r;
    prod         = 36'h000000000;
    sum          = RST_ZERO;
    st_nxt.redir = '0;
    st_nxt.mem   = '0;
    st_nxt.irq_take = irq_req && st_r.allow; // RULE14

    // A returning load lands at the entry captured when it was issued.
    if (ld_valid) begin
      st_nxt.rf[st_r.ld_dst] = ld_data;
    end

    if (instr_valid) begin
      // The instruction after a transfer is the delay slot; the redirect leaves
      // only after that slot has executed.
      if (st_r.pend) begin
        st_nxt.pend  = 1'b0; // RULE26
        st_nxt.redir = '{valid: 1'b1, pc: st_r.pend_pc};
      end
      case (op)
        OP_JMP: begin
          st_nxt.pend    = 1'b1;
          st_nxt.pend_pc = instr_pc + {{5{instr[12]}}, instr[12:0]};
        end
        OP_CALL: begin
          if (st_r.level < LEVEL_MAX) begin
            st_nxt.level = st_r.level + 7'h01; // RULE24 RULE12
          end
          st_nxt.rf[phys_idx(st_nxt.level, REG_LINK)] = link_pc; // RULE24
          st_nxt.pend    = 1'b1;
          st_nxt.pend_pc = instr_pc + {{5{instr[12]}}, instr[12:0]};
        end
        OP_BRZ, OP_BRNZ: begin
          if ((a == RST_ZERO) == (op == OP_BRZ)) begin
            st_nxt.pend    = 1'b1;
            st_nxt.pend_pc = instr_pc + imm_s;
          end
        end
        OP_BFZ, OP_BFNZ: begin
          if (st_r.flag == (op == OP_BFNZ)) begin
            st_nxt.pend    = 1'b1;
            st_nxt.pend_pc = instr_pc + {{5{instr[12]}}, instr[12:0]};
          end
        end
        OP_ADDI: st_nxt.rf[rd_idx] = a + imm_s; // RULE3 RULE22
        OP_MOVI: st_nxt.rf[rd_idx] = imm_z;
        OP_LHI:  st_nxt.rf[rd_idx] = {instr[8:0], 9'h000};
        OP_SEXT: st_nxt.rf[rd_idx] = sext9(a[8:0]);
        OP_ANDI: st_nxt.rf[rd_idx] = a & imm_z;
        OP_ORI:  st_nxt.rf[rd_idx] = a | imm_z;
        OP_XORI: st_nxt.rf[rd_idx] = a ^ imm_z;
        OP_MULI: begin
          prod = a * imm_s;
          st_nxt.rf[rd_idx] = prod[17:0];
          st_nxt.mulhi      = prod[35:18]; // RULE16
        end
        OP_LD9, OP_ST9, OP_LD18, OP_ST18: begin
          // Address bit 17 only reaches memory when the upper flag is set.
          st_nxt.mem.req   = 1'b1; // RULE4
          st_nxt.mem.we    = op[0];
          st_nxt.mem.wide  = op[1];
          st_nxt.mem.addr  = {maddr[17] & st_r.upper, maddr[16:0]}; // RULE13
          st_nxt.mem.wdata = op[1] ? a : {9'h000, a[8:0]};
          st_nxt.ld_dst    = rd_idx;
        end
        OP_SLLI: st_nxt.rf[rd_idx] = a << fn;
        OP_SRLI: st_nxt.rf[rd_idx] = a >> fn;
        OP_SRAI: st_nxt.rf[rd_idx] = 18'($signed(a) >>> fn);
        OP_CADDI: begin
          if (st_r.flag) begin
            st_nxt.rf[rd_idx] = a + imm_z; // RULE5
          end
        end
        OP_CSUBI: begin
          if (st_r.flag) begin
            st_nxt.rf[rd_idx] = a - imm_z; // RULE5
          end
        end
        OP_GRP1: begin
          if (fn == G1_SLL) begin
            st_nxt.rf[rd_idx] = a << b[4:0]; // RULE6
          end else if (fn == G1_MOV) begin
            st_nxt.rf[rd_idx] = b;
          end else if (fn == G1_SRL) begin
            st_nxt.rf[rd_idx] = a >> b[4:0];
          end else if (fn == G1_SRA) begin
            st_nxt.rf[rd_idx] = 18'($signed(a) >>> b[4:0]);
          end else if (fn >= G1_CMP_LO && fn <= G1_CMP_HI) begin
            st_nxt.flag = cmp_sel(fn[2:0], a == b, a < b); // RULE6 RULE17
          end else if (fn == G1_BCLR || fn == G1_BSET) begin
            // Bit number sits in the Rs field; other numbers change nothing.
            if (rs == BIT_FLAG) begin
              st_nxt.flag = fn[0]; // RULE23 RULE11
            end else if (rs == BIT_UPPER) begin
              st_nxt.upper = fn[0]; // RULE23
            end else if (rs == BIT_ALLOW) begin
              st_nxt.allow = fn[0]; // RULE23
            end
          end else if (fn == G1_NOT) begin
            st_nxt.rf[rd_idx] = ~a;
          end
          // Flag or/and and the empty cells fall through unchanged.  RULE8 RULE27
        end
        OP_GRP2: begin
          if (fn == G2_XRET) begin
            st_nxt.allow   = 1'b1;
            st_nxt.pend    = 1'b1;
            st_nxt.pend_pc = st_r.rf[phys_idx(st_r.level, REG_LINK)];
          end else if (fn == G2_TRAP) begin
            st_nxt.tnum    = instr[12:5]; // RULE19
            st_nxt.pend    = 1'b1;
            st_nxt.pend_pc = {st_r.tbase, instr[12:5]};
          end else if (fn == G2_JR || fn == G2_JALR) begin
            st_nxt.pend    = 1'b1; // RULE7
            st_nxt.pend_pc = b;
            if (fn == G2_JALR) begin
              st_nxt.rf[phys_idx(st_r.level, REG_LINK)] = link_pc;
            end
          end else if (fn == G2_RETS) begin
            st_nxt.pend    = 1'b1; // RULE25
            st_nxt.pend_pc = b;
            if (st_r.level != RST_LEVEL) begin
              st_nxt.level = st_r.level - 7'h01; // RULE25
            end
          end else if (fn == G2_CALLR) begin
            if (st_r.level < LEVEL_MAX) begin
              st_nxt.level = st_r.level + 7'h01; // RULE24
            end
            st_nxt.rf[phys_idx(st_nxt.level, REG_LINK)] = link_pc; // RULE24
            st_nxt.pend    = 1'b1;
            st_nxt.pend_pc = b;
          end else if (fn == G2_ADD || fn == G2_SUB) begin
            sum = (fn == G2_ADD) ? a + b : a - b;
            st_nxt.rf[rd_idx] = sum; // RULE21
            st_nxt.flag       = ovf(a, b, sum, fn[1]); // RULE21 RULE17
          end else if (fn == G2_ADDU) begin
            st_nxt.rf[rd_idx] = a + b; // RULE22
          end else if (fn == G2_SUBU) begin
            st_nxt.rf[rd_idx] = a - b;
          end else if (fn == G2_AND) begin
            st_nxt.rf[rd_idx] = a & b; // RULE22
          end else if (fn == G2_OR) begin
            st_nxt.rf[rd_idx] = a | b;
          end else if (fn == G2_XOR) begin
            st_nxt.rf[rd_idx] = a ^ b;
          end else if (fn == G2_MUL) begin
            prod = a * b;
            st_nxt.rf[rd_idx] = prod[17:0];
            st_nxt.mulhi      = prod[35:18]; // RULE16
          end else if (fn >= G2_CMP_LO && fn <= G2_CMP_HI) begin
            st_nxt.flag = cmp_sel(fn[2:0], a == b, $signed(a) < $signed(b)); // RULE7
          end else if (fn == G2_TOSPR) begin
            // Rd names the special register, Rs supplies the value.
            if (rd == SPR_STATUS) begin
              st_nxt.level = b[6:0]; // RULE12
              st_nxt.upper = b[ST_UPPER_POS]; // RULE13
              st_nxt.allow = b[ST_ALLOW_POS]; // RULE14
            end else if (rd == SPR_IND) begin
              st_nxt.ind = b[6:0]; // RULE15
            end else if (rd == SPR_FLAG) begin
              st_nxt.flag = b[0];
            end else if (rd == SPR_HSTART) begin
              st_nxt.hstart = b; // RULE18
            end else if (rd == SPR_TRAP) begin
              st_nxt.tbase = b[17:8]; // RULE19
            end else if (rd == SPR_DBGIDX && DEBUG_EN) begin
              st_nxt.dbg_idx = b;
            end else if (rd == SPR_DBGDAT && DEBUG_EN) begin
              st_nxt.dbg_dat = b;
            end
          end else if (fn == G2_FROMSPR) begin
            st_nxt.rf[rd_idx] = spr_rd; // RULE11
          end
        end
        default: begin
          if (op >= OP_CMPI_LO && op <= OP_CMPI_HI) begin
            st_nxt.flag = cmp_sel(op[2:0], a == imm_s,
                                  $signed(a) < $signed(imm_s)); // RULE5
          end
          // Code 10101 is empty and changes nothing.  RULE27
        end
      endcase
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================

  // Synchronous reset; the register store clears too so simulation starts clean.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_r        <= '0;
      st_r.hstart <= HANDLER_RESET; // RULE18
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs are taken straight from the state flops.
  assign redirect        = st_r.redir;
  assign mem_req         = st_r.mem;
  assign indicators      = st_r.ind; // RULE15
  assign irq_take        = st_r.irq_take;
  assign interrupt_allow = st_r.allow;
  assign window_level    = st_r.level;
  assign condition_flag  = st_r.flag;

endmodule : wcd_core

// ==== src/wcd_pkg.sv ====
package wcd_pkg;

  // ==========================================================================
  // Widths and storage
  // ==========================================================================
  localparam int WORD_W     = 18;
  localparam int RF_DEPTH   = 1024;
  localparam int RF_IDX_W   = 10;
  localparam int WIN_STRIDE = 8;
  localparam logic [6:0] LEVEL_MAX = 7'h7E;
  localparam logic [3:0] REG_LINK  = 4'hB;
  localparam logic [3:0] REG_GLOBAL_TOP = 4'h3;

  // ==========================================================================
  // Special register numbers
  // ==========================================================================
  localparam logic [3:0] SPR_STATUS = 4'h0;
  localparam logic [3:0] SPR_IND    = 4'h1;
  localparam logic [3:0] SPR_MULHI  = 4'h2;
  localparam logic [3:0] SPR_FLAG   = 4'h3;
  localparam logic [3:0] SPR_HSTART = 4'h4;
  localparam logic [3:0] SPR_TRAP   = 4'h5;
  localparam logic [3:0] SPR_DBGIDX = 4'h6;
  localparam logic [3:0] SPR_DBGDAT = 4'h7;

  // Status word field positions and bit numbers for bit set and clear.
  localparam int ST_UPPER_POS = 7;
  localparam int ST_ALLOW_POS = 8;
  localparam logic [3:0] BIT_FLAG  = 4'h0;
  localparam logic [3:0] BIT_UPPER = 4'h1;
  localparam logic [3:0] BIT_ALLOW = 4'h2;

  // Reset values.
  localparam logic [17:0] RST_ZERO = 18'h00000;
  localparam logic [6:0]  RST_LEVEL = 7'h00;

  // ==========================================================================
  // Primary opcodes, instruction bits 17 to 13
  // ==========================================================================
  localparam logic [4:0] OP_GRP1 = 5'h00, OP_GRP2 = 5'h01, OP_JMP = 5'h02, OP_CALL = 5'h03;
  localparam logic [4:0] OP_BRZ = 5'h04, OP_BRNZ = 5'h05, OP_BFZ = 5'h06, OP_BFNZ = 5'h07;
  localparam logic [4:0] OP_ADDI = 5'h08, OP_MOVI = 5'h09, OP_LHI = 5'h0A, OP_SEXT = 5'h0B;
  localparam logic [4:0] OP_ANDI = 5'h0C, OP_ORI = 5'h0D, OP_XORI = 5'h0E, OP_MULI = 5'h0F;
  localparam logic [4:0] OP_LD9 = 5'h10, OP_ST9 = 5'h11, OP_LD18 = 5'h12, OP_ST18 = 5'h13;
  localparam logic [4:0] OP_SLLI = 5'h14, OP_SRLI = 5'h16, OP_SRAI = 5'h17;
  localparam logic [4:0] OP_CMPI_LO = 5'h18, OP_CMPI_HI = 5'h1D;
  localparam logic [4:0] OP_CADDI = 5'h1E, OP_CSUBI = 5'h1F;

  // Group one sub-codes, instruction bits 4 to 0.
  localparam logic [4:0] G1_SLL = 5'h04, G1_MOV = 5'h05, G1_SRL = 5'h06, G1_SRA = 5'h07;
  localparam logic [4:0] G1_CMP_LO = 5'h08, G1_CMP_HI = 5'h0D;
  localparam logic [4:0] G1_BCLR = 5'h16, G1_BSET = 5'h17, G1_NOT = 5'h1F;

  // Group two sub-codes, instruction bits 4 to 0.
  localparam logic [4:0] G2_XRET = 5'h00, G2_TRAP = 5'h01, G2_JR = 5'h02, G2_JALR = 5'h03;
  localparam logic [4:0] G2_RETS = 5'h04, G2_CALLR = 5'h05;
  localparam logic [4:0] G2_ADD = 5'h10, G2_ADDU = 5'h11, G2_SUB = 5'h12, G2_SUBU = 5'h13;
  localparam logic [4:0] G2_AND = 5'h14, G2_OR = 5'h15, G2_XOR = 5'h16, G2_MUL = 5'h17;
  localparam logic [4:0] G2_CMP_LO = 5'h18, G2_CMP_HI = 5'h1D;
  localparam logic [4:0] G2_TOSPR = 5'h1E, G2_FROMSPR = 5'h1F;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic        req;
    logic        we;
    logic        wide;
    logic [17:0] addr;
    logic [17:0] wdata;
  } wcd_mem_req_t;

  typedef struct packed {
    logic        valid;
    logic [17:0] pc;
  } wcd_redirect_t;

  typedef struct packed {
    logic [RF_DEPTH-1:0][17:0] rf;
    logic [6:0]    level;
    logic          upper;
    logic          allow;
    logic [6:0]    ind;
    logic [17:0]   mulhi;
    logic          flag;
    logic [17:0]   hstart;
    logic [9:0]    tbase;
    logic [7:0]    tnum;
    logic [17:0]   dbg_idx;
    logic [17:0]   dbg_dat;
    logic          pend;
    logic [17:0]   pend_pc;
    wcd_redirect_t redir;
    logic          irq_take;
    wcd_mem_req_t  mem;
    logic [9:0]    ld_dst;
  } wcd_state_t;

endpackage : wcd_pkg

// ==== verification/wcd_core_monitor.sv ====
`timescale 1ns/1ps
// ==========================================================================
// Port checker for the decode core
// ==========================================================================
module wcd_core_monitor
  import wcd_pkg::*;
(
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       instr_valid,
  input wire logic       irq_req,
  input wcd_redirect_t   redirect,
  input wcd_mem_req_t    mem_req,
  input wire logic [6:0] indicators,
  input wire logic       irq_take,
  input wire logic       interrupt_allow,
  input wire logic [6:0] window_level,
  input wire logic       condition_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Redirects, memory requests and level, indicator and flag changes must trace back to an instruction taken one edge earlier.
  sequence s_taken;
    $past(instr_valid);
  endsequence
  property p_irq_gate;
    irq_take |-> $past(irq_req && interrupt_allow);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("take without allow");
  property p_irq_block;
    !interrupt_allow |=> !irq_take;
  endproperty
  a_irq_block: assert property (p_irq_block) else $error("take while blocked");
  property p_redir_pulse;
    redirect.valid |=> !redirect.valid;
  endproperty
  a_redir_pulse: assert property (p_redir_pulse) else $error("redirect too long");
  property p_redir_slot;
    redirect.valid |-> s_taken;
  endproperty
  a_redir_slot: assert property (p_redir_slot) else $error("redirect without slot");
  property p_mem_cause;
    mem_req.req |-> s_taken;
  endproperty
  a_mem_cause: assert property (p_mem_cause) else $error("stray memory request");
  property p_level_cause;
    $changed(window_level) |-> s_taken;
  endproperty
  a_level_cause: assert property (p_level_cause) else $error("level moved alone");
  property p_ind_hold;
    $changed(indicators) |-> s_taken;
  endproperty
  a_ind_hold: assert property (p_ind_hold) else $error("indicators moved alone");
  property p_flag_hold;
    $changed(condition_flag) |-> s_taken;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag moved alone");
endmodule : wcd_core_monitor

bind wcd_core wcd_core_monitor u_wcd_core_monitor (.clk(clk), .nrst(nrst),
  .instr_valid(instr_valid), .irq_req(irq_req), .redirect(redirect), .mem_req(mem_req),
  .indicators(indicators), .irq_take(irq_take), .interrupt_allow(interrupt_allow),
  .window_level(window_level), .condition_flag(condition_flag));

// ==== verification/wcd_mem_model.sv ====
`timescale 1ns/1ps
// ==========================================================================
// Data memory stand-in that answers loads after LAT cycles
// ==========================================================================
module wcd_mem_model
  import wcd_pkg::*;
#(
  parameter int LAT = 2
) (
  input wire logic    clk,
  input wire logic    nrst,
  input wcd_mem_req_t mem_req,
  output logic        ld_valid,
  output logic [17:0] ld_data
);
  logic [17:0] addr_r;
  logic        wide_r;
  int          cnt_r;
  // Inputs of the core move on the falling edge only; idle data toggles every
  // cycle so a stale sample never looks like an answer.
  always @(negedge clk) begin
    if (!nrst) begin
      ld_valid <= 1'b0;
      ld_data  <= 18'h00000;
      cnt_r    <= 0;
    end else begin
      ld_valid <= (cnt_r == 1);
      ld_data  <= (cnt_r != 1) ? ~ld_data :
                  wide_r ? addr_r ^ 18'h2A5A5 : {9'h000, addr_r[8:0] ^ 9'h0A5};
      if (mem_req.req && !mem_req.we) begin
        addr_r <= mem_req.addr;
        wide_r <= mem_req.wide;
        cnt_r  <= LAT;
      end else if (cnt_r > 0) begin
        cnt_r <= cnt_r - 1;
      end
    end
  end
endmodule : wcd_mem_model

// ==== verification/test_wcd_core.sv ====
`timescale 1ns/1ps
// ==========================================================================
// Self-checking bench for the decode core
// ==========================================================================
module test_wcd_core
  import wcd_pkg::*;
;
  localparam int LAT = 3;
  logic          clk, nrst, instr_valid, ld_valid, irq_req;
  logic          irq_take, interrupt_allow, condition_flag;
  logic [17:0]   instr, instr_pc, ld_data, wd, wa, rpc, pc, p;
  logic [6:0]    indicators, window_level;
  logic [35:0]   prod;
  wcd_redirect_t redirect;
  wcd_mem_req_t  mem_req;
  int            n_mismatch, checks_done, n_red, n_irq, k;

  wcd_core u_wcd_core (.clk(clk), .nrst(nrst), .instr_valid(instr_valid), .instr(instr),
    .instr_pc(instr_pc), .ld_valid(ld_valid), .ld_data(ld_data), .irq_req(irq_req),
    .redirect(redirect), .mem_req(mem_req), .indicators(indicators), .irq_take(irq_take),
    .interrupt_allow(interrupt_allow), .window_level(window_level),
    .condition_flag(condition_flag));
  wcd_mem_model #(.LAT(LAT)) u_wcd_mem_model (.clk(clk), .nrst(nrst), .mem_req(mem_req),
    .ld_valid(ld_valid), .ld_data(ld_data));

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Pulses are logged on the edge so checks need not hit the exact cycle.
  always @(posedge clk) begin
    if (mem_req.req) begin
      wd = mem_req.wdata;
      wa = mem_req.addr;
    end
    if (redirect.valid) begin
      n_red++;
      rpc = redirect.pc;
    end
    if (irq_take) n_irq++;
  end

  // ==========================================================================
  // Access tasks
  // ==========================================================================
  task automatic print_verdict;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  // Issues one instruction; valid stays high so calls run back to back.
  task automatic ex(input logic [17:0] w);
    @(negedge clk);
    instr = w;
    instr_pc = pc;
    instr_valid = 1'b1;
    pc = pc + 18'h00001;
  endtask : ex
  task automatic idle(input int n);
    @(negedge clk);
    instr_valid = 1'b0;
    repeat (n) @(negedge clk);
  endtask : idle
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Registers are seen only through a full-word store from base zero.
  task automatic sreg(input logic [3:0] r, input logic [17:0] exp);
    ex({OP_ST18, r, 9'h000});
    idle(2);
    chk(wd, exp);
  endtask : sreg
  task automatic cf(input logic e);
    chk({17'h0, condition_flag}, {17'h0, e});
  endtask : cf
  function automatic logic [17:0] g2(input logic [3:0] d, s, input logic [4:0] f);
    return {OP_GRP2, d, s, f};
  endfunction : g2

  // Hang guard, far beyond the roughly 170 cycles the sequence needs.
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end

  // ==========================================================================
  // Test sequence
  // ==========================================================================
  initial begin
    nrst = 1'b0;
    instr_valid = 1'b0;
    instr = 18'h00000;
    instr_pc = 18'h00000;
    irq_req = 1'b0;
    pc = 18'h00100;
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    chk({2'h0, interrupt_allow, condition_flag, indicators, window_level}, 18'h0);
    ex({OP_MOVI, 4'h1, 9'h1FF});
    sreg(4'h1, 18'h001FF);
    ex({OP_ADDI, 4'h1, 9'h1FF});
    sreg(4'h1, 18'h001FE);
    ex({OP_LHI, 4'h2, 9'h07F});
    ex(g2(4'h2, 4'h1, G2_MUL));
    ex(g2(4'h3, SPR_MULHI, G2_FROMSPR));
    prod = 36'h00000FE00 * 36'h0000001FE;
    sreg(4'h3, prod[35:18]);
    sreg(4'h2, prod[17:0]);
    ex({OP_LHI, 4'h2, 9'h0FF});
    ex(g2(4'h2, 4'h2, G2_ADD));
    sreg(4'h2, 18'h3FC00);
    cf(1'b1);
    ex(g2(4'h2, 4'h1, G2_ADDU));
    sreg(4'h2, 18'h3FDFE);
    cf(1'b1);
    ex(g2(4'h2, 4'h1, G2_AND));
    sreg(4'h2, 18'h3FDFE & 18'h001FE);
    ex(g2(4'h1, 4'h1, G2_ADD));
    ex(g2(SPR_IND, 4'h1, G2_TOSPR));
    ex(g2(SPR_TRAP, 4'h1, G2_TOSPR));
    ex(g2(4'h3, SPR_TRAP, G2_FROMSPR));
    sreg(4'h3, 18'h00300);
    cf(1'b0);
    chk({11'h0, indicators}, 18'h0007C);
    for (k = 6; k < 8; k++) begin
      ex(g2(4'(k), 4'h1, G2_TOSPR));
      ex(g2(4'h3, 4'(k), G2_FROMSPR));
      sreg(4'h3, 18'h00000);
    end
    // Bit numbers 0 to 2 reach the flags; number 3 must do nothing.
    ex({OP_LHI, 4'h4, 9'h100});
    irq_req = 1'b1;
    for (k = 0; k < 4; k++) ex({OP_GRP1, 4'h0, 4'(k), G1_BSET});
    ex(g2(4'h3, SPR_STATUS, G2_FROMSPR));
    sreg(4'h3, 18'h00180);
    chk({16'h0, interrupt_allow, condition_flag}, 18'h3);
    chk(18'(n_irq > 0), 18'h1);
    ex({OP_ST18, 4'h1, 4'h4, 5'h00});
    idle(2);
    chk(wa, 18'h20000);
    for (k = 0; k < 3; k++) ex({OP_GRP1, 4'h0, 4'(k), G1_BCLR});
    ex({OP_ST18, 4'h1, 4'h4, 5'h00});
    idle(2);
    chk(wa, 18'h00000);
    chk({15'h0, irq_take, interrupt_allow, condition_flag}, 18'h0);
    irq_req = 1'b0;
    k = n_red;
    ex({5'h15, 13'h1FFF});
    ex({OP_GRP1, 4'h1, 4'h1, 5'h00});
    sreg(4'h1, 18'h003FC);
    chk(18'(n_red - k), 18'h0);
    // Signed immediate compares of five against five, eq through ge.
    ex({OP_MOVI, 4'h5, 9'h005});
    for (k = 0; k < 6; k++) begin
      ex({OP_CMPI_LO + 5'(k), 4'h5, 9'h005});
      idle(1);
      cf(k == 0 || k > 3);
    end
    k = n_red;
    p = pc;
    ex({OP_BFZ, 13'h0006});
    ex({OP_BRNZ, 4'h0, 9'h004});
    ex({OP_BFNZ, 13'h1FFE});
    ex({OP_MOVI, 4'h3, 9'h044});
    idle(2);
    chk(18'(n_red - k), 18'h1);
    chk(rpc, p);
    sreg(4'h3, 18'h00044);
    // Call shifts the window: caller r12 shows up as callee r4.
    ex({OP_MOVI, 4'hC, 9'h0AB});
    p = pc;
    ex({OP_CALL, 13'h0010});
    ex({OP_MOVI, 4'h3, 9'h055});
    idle(2);
    chk(rpc, p + 18'h00010);
    chk({11'h0, window_level}, 18'h1);
    sreg(4'h4, 18'h000AB);
    sreg(REG_LINK, p + 18'h00002);
    ex(g2(4'h0, REG_LINK, G2_RETS));
    ex({OP_MOVI, 4'h3, 9'h066});
    idle(2);
    chk(rpc, p + 18'h00002);
    chk({11'h0, window_level}, 18'h0);
    ex({OP_LD18, 4'h7, 4'h0, 5'h02});
    idle(LAT + 4);
    chk(wa, 18'h00002);
    sreg(4'h7, 18'h00002 ^ 18'h2A5A5);
    ex({OP_LD9, 4'h8, 4'h0, 5'h03});
    idle(LAT + 4);
    sreg(4'h8, {9'h000, 9'h003 ^ 9'h0A5});
    print_verdict();
  end
endmodule : test_wcd_core
